// >>> hdl/bvs_voltage_regs.sv
// operating and alternate voltage registers for buck converters one and two, limit register for converter one only
module bvs_voltage_regs (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire bvs_pkg::bvs_req_t reg_req,
	output logic [7:0]             reg_rdata,
	input  wire bvs_pkg::bvs_otp_t otp_defaults,
	input  wire logic              otp_reload,
	input  wire logic [5:0]        buck2_ceiling,
	input  wire logic [2:0]        step_time1,
	input  wire logic [2:0]        step_time2,
	input  wire logic              step_bypass,
	input  wire logic [1:0]        set_off,
	output logic [5:0]             buck1_code,
	output logic [5:0]             buck2_code,
	output logic [1:0]             buck_enable,
	output logic [1:0]             buck_eco,
	output logic [1:0]             buck1_range,
	output logic                   limit_locked,
	output logic [1:0]             ramp_busy
);
	import bvs_pkg::*;

	// load pending from reset so defaults are latched by a clock, not by the reset
	logic       load_r;
	logic [1:0] selector_r;
	logic [5:0] opr_code_r [2];
	logic [1:0] alt_enable_r;
	logic [1:0] alt_eco_r;
	logic [5:0] alt_code_r [2];
	logic [7:0] rdata_r;
	logic [1:0] enable_r;
	logic [7:0] limit_val;

	wire logic load = load_r | otp_reload;

	wire logic wr_b1_opr = reg_req.wr && reg_req.addr == BVS_OFS_B1_OPR;
	wire logic wr_b1_alt = reg_req.wr && reg_req.addr == BVS_OFS_B1_ALT;
	wire logic wr_b1_lim = reg_req.wr && reg_req.addr == BVS_OFS_B1_LIM;
	wire logic wr_b2_opr = reg_req.wr && reg_req.addr == BVS_OFS_B2_OPR;
	wire logic wr_b2_alt = reg_req.wr && reg_req.addr == BVS_OFS_B2_ALT;

	wire logic [1:0] wr_opr = {wr_b2_opr, wr_b1_opr};
	wire logic [1:0] wr_alt = {wr_b2_alt, wr_b1_alt};

	wire logic [5:0] ceiling [2];
	assign ceiling[0] = limit_val[5:0];
	assign ceiling[1] = buck2_ceiling;

	wire logic [5:0] wcode_clamped [2];
	assign wcode_clamped[0] = bvs_clamp(reg_req.wdata[5:0], ceiling[0]);
	assign wcode_clamped[1] = bvs_clamp(reg_req.wdata[5:0], ceiling[1]);

	wire bvs_otp_buck_t otp_buck [2];
	assign otp_buck[0] = otp_defaults.b1;
	assign otp_buck[1] = otp_defaults.b2;

	// reserved bit 7 always reads zero
	wire logic [7:0] opr_view [2];
	wire logic [7:0] alt_view [2];
	assign opr_view[0] = {1'b0, selector_r[0], opr_code_r[0]};
	assign opr_view[1] = {1'b0, selector_r[1], opr_code_r[1]};
	assign alt_view[0] = {alt_enable_r[0], alt_eco_r[0], alt_code_r[0]};
	assign alt_view[1] = {alt_enable_r[1], alt_eco_r[1], alt_code_r[1]};

	wire logic [7:0] rd_mux =
		(reg_req.addr == BVS_OFS_B1_OPR) ? opr_view[0] :
		(reg_req.addr == BVS_OFS_B1_ALT) ? alt_view[0] :
		(reg_req.addr == BVS_OFS_B1_LIM) ? limit_val :
		(reg_req.addr == BVS_OFS_B2_OPR) ? opr_view[1] :
		(reg_req.addr == BVS_OFS_B2_ALT) ? alt_view[1] : BVS_UNMAPPED_READ;

	// target code: selector low picks operating, high picks alternate
	wire logic [5:0] target [2];
	assign target[0] = selector_r[0] ? alt_code_r[0] : opr_code_r[0];
	assign target[1] = selector_r[1] ? alt_code_r[1] : opr_code_r[1];

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			load_r <= 1'b1;
		end else begin
			load_r <= 1'b0;
		end
	end

	for (genvar i = 0; i < 2; i++) begin : g_buck
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				selector_r[i]   <= BVS_SELECTOR_RESET;
				opr_code_r[i]   <= 6'h00;
				alt_enable_r[i] <= 1'b0;
				alt_eco_r[i]    <= BVS_ECO_RESET;
				alt_code_r[i]   <= 6'h00;
			end else if (load) begin
				selector_r[i]   <= BVS_SELECTOR_RESET;
				opr_code_r[i]   <= otp_buck[i].opr_code;
				alt_enable_r[i] <= otp_buck[i].alt_enable;
				alt_eco_r[i]    <= BVS_ECO_RESET;
				alt_code_r[i]   <= otp_buck[i].alt_code;
			end else begin
				if (wr_opr[i]) begin
					selector_r[i] <= reg_req.wdata[BVS_OPR_SELECTOR_BIT];
					opr_code_r[i] <= wcode_clamped[i];
				end
				if (wr_alt[i]) begin
					alt_enable_r[i] <= reg_req.wdata[BVS_ALT_ENABLE_BIT];
					alt_eco_r[i]    <= reg_req.wdata[BVS_ALT_ECO_BIT];
					alt_code_r[i]   <= wcode_clamped[i];
				end
			end
		end
	end

	// forced-off overrides the enable bit without altering what software reads back
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			enable_r <= 2'b00;
			rdata_r  <= 8'h00;
		end else begin
			enable_r <= alt_enable_r & ~set_off;
			if (reg_req.rd) begin
				rdata_r <= rd_mux;
			end
		end
	end

	bvs_limit_reg u_limit (
		.sys_clk     (sys_clk),
		.rst         (rst),
		.load        (load),
		.otp_range   (otp_defaults.b1_range),
		.otp_ceiling (otp_defaults.b1_ceiling),
		.wr_en       (wr_b1_lim),
		.wdata       (reg_req.wdata),
		.limit_r     (limit_val),
		.locked_r    (limit_locked)
	);

	bvs_slew_ramp u_ramp1 (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.target    (target[0]),
		.step_time (step_time1),
		.bypass    (step_bypass),
		.code_r    (buck1_code),
		.moving_r  (ramp_busy[0])
	);

	bvs_slew_ramp u_ramp2 (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.target    (target[1]),
		.step_time (step_time2),
		.bypass    (step_bypass),
		.code_r    (buck2_code),
		.moving_r  (ramp_busy[1])
	);

	assign reg_rdata   = rdata_r;
	assign buck_enable = enable_r;
	assign buck_eco    = alt_eco_r;
	assign buck1_range = limit_val[7:BVS_LIM_RANGE_LSB];

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_reserved_reads_zero: assert property (
		reg_req.rd && (reg_req.addr == BVS_OFS_B1_OPR || reg_req.addr == BVS_OFS_B2_OPR)
			|=> reg_rdata[BVS_OPR_RESERVED_BIT] == 1'b0)
		else $error("reserved operating bit read back as one");
	a_write_clamped: assert property (
		wr_b1_opr && !load |=> opr_code_r[0] <= $past(ceiling[0])
			&& (opr_code_r[0] == $past(reg_req.wdata[5:0]) || opr_code_r[0] == $past(ceiling[0])))
		else $error("operating code not limited to ceiling");
	a_load_clears_bits: assert property (
		load |=> selector_r == 2'b00 && alt_eco_r == 2'b00
			&& alt_code_r[0] == $past(otp_defaults.b1.alt_code))
		else $error("default load left selector, eco or code wrong");
	a_forced_off_wins: assert property (
		set_off[1] || !alt_enable_r[1] |=> !buck_enable[1])
		else $error("converter enabled while forced off or disabled");

	c_alt_selected: cover property (wr_b1_opr && reg_req.wdata[BVS_OPR_SELECTOR_BIT] ##1 selector_r[0]);
	c_clamp_hit: cover property (wr_b2_alt && !load && reg_req.wdata[5:0] > ceiling[1]);
endmodule : bvs_voltage_regs

// >>> shared/bvs_pkg.sv
// buck voltage select register bank: offsets, fields, defaults, slew timing, carriers
package bvs_pkg;

	localparam logic [7:0] BVS_OFS_B1_OPR = 8'h04;
	localparam logic [7:0] BVS_OFS_B1_ALT = 8'h05;
	localparam logic [7:0] BVS_OFS_B1_LIM = 8'h06;
	localparam logic [7:0] BVS_OFS_B2_OPR = 8'h07;
	localparam logic [7:0] BVS_OFS_B2_ALT = 8'h08;

	localparam int BVS_OPR_RESERVED_BIT = 7;
	localparam int BVS_OPR_SELECTOR_BIT = 6;
	localparam int BVS_ALT_ENABLE_BIT   = 7;
	localparam int BVS_ALT_ECO_BIT      = 6;
	localparam int BVS_LIM_RANGE_LSB    = 6;

	localparam logic [5:0] BVS_CEIL_OPEN = 6'h3f;
	localparam logic [5:0] BVS_CEIL_ZERO = 6'h00;
	localparam logic       BVS_SELECTOR_RESET = 1'b0;
	localparam logic       BVS_ECO_RESET      = 1'b0;
	localparam logic [7:0] BVS_UNMAPPED_READ  = 8'h00;

	// clock rate and the output change taken as one code step
	localparam int CLK_MHZ      = 250;
	localparam int CODE_STEP_MV = 10;
	localparam int BVS_CNT_W    = 11;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} bvs_req_t;

	typedef struct packed {
		logic [5:0] opr_code;
		logic       alt_enable;
		logic [5:0] alt_code;
	} bvs_otp_buck_t;

	typedef struct packed {
		bvs_otp_buck_t b1;
		bvs_otp_buck_t b2;
		logic [1:0]    b1_range;
		logic [5:0]    b1_ceiling;
	} bvs_otp_t;

	// slew rate in hundredths of mV/us per step-time code
	function automatic int bvs_slew_centi(input logic [2:0] code);
		case (code)
			3'h0: return 3000;
			3'h1: return 1250;
			3'h2: return 940;
			3'h3: return 750;
			3'h4: return 625;
			3'h5: return 470;
			3'h6: return 312;
			default: return 250;
		endcase
	endfunction : bvs_slew_centi

	// cycles between code steps; every figure rounds down, never below one
	function automatic logic [BVS_CNT_W-1:0] bvs_step_cycles(input logic [2:0] code);
		int c;
		c = (CODE_STEP_MV * 100 * CLK_MHZ) / bvs_slew_centi(code);
		if (c < 1) c = 1;
		return BVS_CNT_W'(c);
	endfunction : bvs_step_cycles

	function automatic logic [5:0] bvs_clamp(input logic [5:0] code, input logic [5:0] ceil);
		return (code > ceil) ? ceil : code;
	endfunction : bvs_clamp

	function automatic logic bvs_ceiling_locks(input logic [5:0] ceil);
		return (ceil != BVS_CEIL_OPEN) && (ceil != BVS_CEIL_ZERO);
	endfunction : bvs_ceiling_locks

endpackage : bvs_pkg

// >>> hdl/bvs_slew_ramp.sv
// steps a converter's output code toward its target at the programmed slew rate
module bvs_slew_ramp (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic [5:0] target,
	input  wire logic [2:0] step_time,
	input  wire logic       bypass,
	output logic      [5:0] code_r,
	output logic            moving_r
);
	import bvs_pkg::*;

	logic [BVS_CNT_W-1:0] cnt_r;
	wire  logic           at_target = (code_r == target);
	wire  logic           cnt_done  = (cnt_r >= bvs_step_cycles(step_time) - BVS_CNT_W'(1));
	wire  logic [5:0]     code_step = (target > code_r) ? code_r + 6'h01 : code_r - 6'h01;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			code_r   <= 6'h00;
			cnt_r    <= '0;
			moving_r <= 1'b0;
		end else if (bypass) begin
			code_r   <= target;
			cnt_r    <= '0;
			moving_r <= 1'b0;
		end else if (!at_target) begin
			moving_r <= 1'b1;
			if (cnt_done) begin
				code_r <= code_step;
				cnt_r  <= '0;
			end else begin
				cnt_r <= cnt_r + BVS_CNT_W'(1);
			end
		end else begin
			cnt_r    <= '0;
			moving_r <= 1'b0;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_ramp_single_step: assert property (
		!bypass |=> (code_r == $past(code_r)) || (code_r == $past(code_r) + 6'h01)
			|| (code_r == $past(code_r) - 6'h01))
		else $error("ramp moved more than one code in a cycle");
	a_ramp_step_pace: assert property (
		(!bypass && !at_target && cnt_r == '0 && step_time == 3'h0 && $stable(target))
			##1 (!bypass && $stable(step_time) && $stable(target)) [*8]
			|-> code_r == $past(code_r, 8))
		else $error("ramp stepped faster than the fastest slew rate");
	c_ramp_moves: cover property (!bypass && !at_target ##1 moving_r);
endmodule : bvs_slew_ramp

// >>> hdl/bvs_limit_reg.sv
// converter one limit register: range and ceiling, locked once a real ceiling is set
module bvs_limit_reg (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       load,
	input  wire logic [1:0] otp_range,
	input  wire logic [5:0] otp_ceiling,
	input  wire logic       wr_en,
	input  wire logic [7:0] wdata,
	output logic      [7:0] limit_r,
	output logic            locked_r
);
	import bvs_pkg::*;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			limit_r  <= 8'h00;
			locked_r <= 1'b0;
		end else if (load) begin
			limit_r  <= {otp_range, otp_ceiling};
			locked_r <= bvs_ceiling_locks(otp_ceiling);
		end else if (wr_en && !locked_r) begin
			limit_r  <= wdata;
			locked_r <= bvs_ceiling_locks(wdata[5:0]);
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_lock_holds_limit: assert property (
		locked_r && !load |=> $stable(limit_r))
		else $error("limit register changed while locked");
	a_lock_from_load: assert property (
		load |=> locked_r == bvs_ceiling_locks($past(otp_ceiling)) && limit_r[5:0] == $past(otp_ceiling))
		else $error("lock state wrong after default load");
	c_lock_by_write: cover property (!locked_r && wr_en && !load ##1 locked_r);
endmodule : bvs_limit_reg

// >>> bench/bvs_host.sv
// host model issuing single-byte register reads and writes on the request port
module bvs_host (
	output bvs_pkg::bvs_req_t req,
	input  wire logic         sys_clk,
	input  wire logic [7:0]   rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	import bvs_pkg::*;

	initial req = '0;

	// request held over one sampling edge, then dropped; read data lands on that edge
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge sys_clk);
		req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge sys_clk);
		req <= '0;
		#1;
		q = rdata;
	endtask : access

endmodule : bvs_host

// >>> bench/testbench.sv
// register bank bench: defaults, ramp pacing, clamp, lock and enable checks
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import bvs_pkg::*;

	localparam bvs_otp_t OTP = '{b1: '{opr_code: 6'h0a, alt_enable: 1'b1, alt_code: 6'h0c},
		b2: '{opr_code: 6'h05, alt_enable: 1'b0, alt_code: 6'h07},
		b1_range: 2'h2, b1_ceiling: 6'h3f};

	logic       sys_clk;
	logic       rst;
	bvs_req_t   reg_req;
	logic [7:0] reg_rdata;
	logic       otp_reload;
	logic [5:0] buck2_ceiling;
	logic [2:0] step_time1;
	logic [2:0] step_time2;
	logic       step_bypass;
	logic [1:0] set_off;
	logic [5:0] buck1_code;
	logic [5:0] buck2_code;
	logic [1:0] buck_enable;
	logic [1:0] buck_eco;
	logic [1:0] buck1_range;
	logic       limit_locked;
	logic [1:0] ramp_busy;
	int         fails = 0;
	int         compares = 0;
	int         steps[8] = '{83, 200, 265, 333, 400, 531, 801, 1000};
	logic [5:0] code;

	bvs_voltage_regs dut (.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .otp_defaults(OTP), .otp_reload(otp_reload),
		.buck2_ceiling(buck2_ceiling), .step_time1(step_time1), .step_time2(step_time2),
		.step_bypass(step_bypass), .set_off(set_off), .buck1_code(buck1_code),
		.buck2_code(buck2_code), .buck_enable(buck_enable), .buck_eco(buck_eco),
		.buck1_range(buck1_range), .limit_locked(limit_locked), .ramp_busy(ramp_busy));

	bvs_host u_host (.req(reg_req), .sys_clk(sys_clk), .rdata(reg_rdata));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic complete_run;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		u_host.access(1'b1, a, d, q);
	endtask : wr

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
		logic [7:0] q;
		u_host.access(1'b0, a, 8'h00, q);
		chk(q, exp, what);
	endtask : rchk

	// bounded wait for the ramp; running out ends the run
	task automatic wait_code(input logic [5:0] exp, input int lim);
		for (int n = 0; n < lim && buck1_code !== exp; n++)
			tick(1);
		chk(buck1_code, exp, "ramp end");
		if (buck1_code !== exp)
			complete_run();
	endtask : wait_code

	task automatic do_reset;
		@(posedge sys_clk);
		rst <= 1'b1;
		tick(2);
		@(posedge sys_clk);
		rst <= 1'b0;
		tick(2);
	endtask : do_reset

	task automatic chk_defaults;
		rchk(BVS_OFS_B1_OPR, {2'b00, OTP.b1.opr_code}, "b1 opr");
		rchk(BVS_OFS_B1_ALT, {OTP.b1.alt_enable, 1'b0, OTP.b1.alt_code}, "b1 alt");
		rchk(BVS_OFS_B1_LIM, {OTP.b1_range, OTP.b1_ceiling}, "b1 lim");
		rchk(BVS_OFS_B2_OPR, {2'b00, OTP.b2.opr_code}, "b2 opr");
		rchk(BVS_OFS_B2_ALT, {OTP.b2.alt_enable, 1'b0, OTP.b2.alt_code}, "b2 alt");
		chk(buck1_code, OTP.b1.opr_code, "b1 code");
		chk(buck_eco, 2'b00, "eco");
		chk(buck_enable, {OTP.b2.alt_enable, OTP.b1.alt_enable}, "enables");
		chk(buck1_range, OTP.b1_range, "range");
	endtask : chk_defaults

	initial begin
		rst = 1'b1;
		otp_reload = 1'b0;
		buck2_ceiling = 6'h3f;
		step_time1 = 3'h0;
		step_time2 = 3'h0;
		step_bypass = 1'b1;
		set_off = 2'b00;
		do_reset();
		chk_defaults();
		rchk(8'h09, BVS_UNMAPPED_READ, "unmapped");
		// one code step per setting; early look before the step, bounded wait after
		for (int i = 0; i < 8; i++) begin
			@(posedge sys_clk);
			step_bypass <= 1'b0;
			step_time1 <= 3'(i);
			code = 6'h0b + 6'(i);
			wr(BVS_OFS_B1_OPR, {2'b00, code});
			tick(steps[i] * 3 / 4);
			chk(buck1_code, code - 6'h01, "ramp early");
			chk(ramp_busy[0], 1'b1, "busy");
			wait_code(code, steps[i] / 2 + 8);
		end
		@(posedge sys_clk);
		step_bypass <= 1'b1;
		wr(BVS_OFS_B1_OPR, 8'hc5); // reserved bit set on purpose
		rchk(BVS_OFS_B1_OPR, 8'h45, "reserved");
		chk(buck1_code, OTP.b1.alt_code, "alt target");
		wr(BVS_OFS_B1_ALT, 8'h4c);
		rchk(BVS_OFS_B1_ALT, 8'h4c, "eco");
		chk(buck_enable[0], 1'b0, "disabled");
		chk(buck_eco[0], 1'b1, "eco out");
		wr(BVS_OFS_B1_ALT, 8'h8c);
		@(posedge sys_clk);
		set_off <= 2'b01;
		tick(2);
		chk(buck_enable[0], 1'b0, "forced off");
		@(posedge sys_clk);
		set_off <= 2'b00;
		tick(2);
		chk(buck_enable[0], 1'b1, "enabled");
		wr(BVS_OFS_B1_LIM, 8'h50);
		rchk(BVS_OFS_B1_LIM, 8'h50, "limit");
		chk(limit_locked, 1'b1, "locked");
		chk(buck1_range, 2'h1, "range");
		wr(BVS_OFS_B1_OPR, 8'h3f);
		rchk(BVS_OFS_B1_OPR, 8'h10, "clamp opr");
		wr(BVS_OFS_B1_ALT, 8'hbf);
		rchk(BVS_OFS_B1_ALT, 8'h90, "clamp alt");
		wr(BVS_OFS_B1_LIM, 8'hff);
		rchk(BVS_OFS_B1_LIM, 8'h50, "lock hold");
		@(posedge sys_clk);
		buck2_ceiling <= 6'h20;
		wr(BVS_OFS_B2_ALT, 8'h30);
		rchk(BVS_OFS_B2_ALT, 8'h20, "b2 clamp");
		wr(BVS_OFS_B2_OPR, 8'h05);
		rchk(BVS_OFS_B2_OPR, 8'h05, "b2 opr");
		chk(buck2_code, 6'h05, "b2 code");
		chk(ramp_busy, 2'b00, "idle");
		@(posedge sys_clk);
		otp_reload <= 1'b1;
		@(posedge sys_clk);
		otp_reload <= 1'b0;
		tick(2);
		rchk(BVS_OFS_B1_LIM, {OTP.b1_range, OTP.b1_ceiling}, "reload");
		chk(limit_locked, 1'b0, "unlocked");
		wr(BVS_OFS_B1_OPR, 8'h22);
		do_reset();
		chk_defaults();
		complete_run();
	end

endmodule : testbench
